// ---- csi_pkg.sv ----
// Shared constants and types of the sensor two-wire slave port
package csi_pkg;
	// Bus addressing
	localparam logic [6:0] DEV_ADDR      = 7'h48;
	localparam logic [6:0] GC_ADDR       = 7'h00;
	localparam logic [7:0] GC_RESET_CMD  = 8'h06;
	localparam logic [7:0] PTR_RESET_CMD = 8'hBF;
	// Register pointers
	localparam logic [7:0] PTR_STATUS    = 8'h00;
	localparam logic [7:0] PTR_OFFSET    = 8'h11;
	localparam logic [7:0] PTR_SERIAL0   = 8'h13;
	localparam logic [7:0] PTR_SERIAL1   = 8'h14;
	localparam logic [7:0] PTR_SERIAL2   = 8'h15;
	localparam logic [7:0] PTR_SERIAL3   = 8'h16;
	localparam logic [7:0] PTR_IDENTITY  = 8'h17;
	// Offset control register layout and value after reset
	localparam int         DAC_EN_BIT    = 7;
	localparam int         AUTO_BIT      = 6;
	localparam int         CODE_W        = 6;
	localparam logic [7:0] OFFSET_RESET  = 8'hC0;
	localparam logic [5:0] CODE_MIN      = 6'h00;
	localparam logic [5:0] CODE_MAX      = 6'h3F;
	// Data average thresholds, quarter and three quarters of full range
	localparam int          AVG_W        = 16;
	localparam logic [15:0] AVG_HIGH     = 16'hC000;
	localparam logic [15:0] AVG_LOW      = 16'h4000;
	// Frame bit count
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Reload time
	localparam int RELOAD_TIME_US = 2000;
	localparam int CLK_FREQ_MHZ   = 100;
	localparam int RELOAD_CYCLES  = RELOAD_TIME_US * CLK_FREQ_MHZ;
	typedef enum logic [7:0] {
		ST_IDLE  = 8'h01,
		ST_ADDR  = 8'h02,
		ST_AACK  = 8'h04,
		ST_RX    = 8'h08,
		ST_RACK  = 8'h10,
		ST_TX    = 8'h20,
		ST_TACK  = 8'h40,
		ST_TLOAD = 8'h80
	} csi_state_t;
endpackage

// ---- csi_sync.sv ----
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
`default_nettype none
module csi_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	initial begin
		if (WIDTH < 1) begin
			$error("csi_sync: WIDTH must be at least 1");
		end
	end

	// Idle bus level is high, so reset to ones to avoid a false start
	always_comb begin
		meta_next = async_i;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ---- csi_auto_track.sv ----
// Automatic offset code tracking from the data average
`timescale 1ns/1ps
`default_nettype none
module csi_auto_track #(
	parameter int AVG_W  = csi_pkg::AVG_W,
	parameter int CODE_W = csi_pkg::CODE_W
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	// Control
	input  wire logic              track_en_i,
	input  wire logic              avg_valid_i,
	input  wire logic [AVG_W-1:0]  avg_i,
	input  wire logic [CODE_W-1:0] step_i,
	input  wire logic [CODE_W-1:0] code_i,
	// Result
	output logic                   upd_o,
	output logic      [CODE_W-1:0] code_o
);
	logic              upd_reg;
	logic              upd_next;
	logic [CODE_W-1:0] code_reg;
	logic [CODE_W-1:0] code_next;

	initial begin
		if (AVG_W != csi_pkg::AVG_W || CODE_W != csi_pkg::CODE_W) begin
			$error("csi_auto_track: widths must match the package thresholds");
		end
	end

	// Saturating steps so a large step never wraps the code
	always_comb begin
		upd_next  = 1'b0;
		code_next = code_reg;
		if (track_en_i && avg_valid_i) begin
			if (avg_i > csi_pkg::AVG_HIGH) begin
				upd_next  = 1'b1;
				code_next = (code_i > csi_pkg::CODE_MAX - step_i) ? csi_pkg::CODE_MAX
				          : code_i + step_i;
			end else if (avg_i < csi_pkg::AVG_LOW) begin
				upd_next  = 1'b1;
				code_next = (code_i < csi_pkg::CODE_MIN + step_i) ? csi_pkg::CODE_MIN
				          : code_i - step_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			upd_reg  <= 1'b0;
			code_reg <= '0;
		end else begin
			upd_reg  <= upd_next;
			code_reg <= code_next;
		end
	end

	assign upd_o  = upd_reg;
	assign code_o = code_reg;
endmodule
`default_nettype wire

// ---- csi_i2c_slave.sv ----
// Two-wire slave port with pointer, offset control, serial number and identity
`timescale 1ns/1ps
`default_nettype none
module csi_i2c_slave #(
	parameter int          RELOAD_CYC = csi_pkg::RELOAD_CYCLES,
	parameter logic [31:0] SERIAL_NUM = 32'h0000_0000, // Arbitrary value
	parameter logic [7:0]  PART_ID    = 8'h00          // Arbitrary value
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	// Serial bus
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_n_o,
	// Other registers of the device
	output logic      [7:0]  ext_addr_o,
	input  wire logic [7:0]  ext_rd_data_i,
	output logic             ext_wr_o,
	output logic      [7:0]  ext_wr_addr_o,
	output logic      [7:0]  ext_wr_data_o,
	output logic             reload_o,
	// Converter side
	input  wire logic        adaptive_mode_i,
	input  wire logic        avg_valid_i,
	input  wire logic [15:0] avg_i,
	input  wire logic [5:0]  range_step_i,
	output logic             offset_dac_enable_o,
	output logic             offset_auto_track_enable_o,
	output logic      [5:0]  offset_code_o
);
	localparam int BW = $clog2(RELOAD_CYC + 1);
	localparam logic [BW-1:0] RELOAD_LOAD = BW'(RELOAD_CYC);

	initial begin
		if (RELOAD_CYC < 1) begin
			$error("csi_i2c_slave: RELOAD_CYC must be at least 1");
		end
	end

	logic [1:0] sync_w;
	logic       scl_s;
	logic       sda_s;
	logic       scl_d_reg;
	logic       sda_d_reg;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_det;
	logic       stop_det;
	logic       trk_upd;
	logic [5:0] trk_code;
	logic       busy;

	// Local names for the package's one-hot state codes
	typedef csi_pkg::csi_state_t csi_st_t;
	localparam csi_st_t ST_IDLE  = csi_pkg::ST_IDLE;
	localparam csi_st_t ST_ADDR  = csi_pkg::ST_ADDR;
	localparam csi_st_t ST_AACK  = csi_pkg::ST_AACK;
	localparam csi_st_t ST_RX    = csi_pkg::ST_RX;
	localparam csi_st_t ST_RACK  = csi_pkg::ST_RACK;
	localparam csi_st_t ST_TX    = csi_pkg::ST_TX;
	localparam csi_st_t ST_TACK  = csi_pkg::ST_TACK;
	localparam csi_st_t ST_TLOAD = csi_pkg::ST_TLOAD;

	csi_st_t       st_reg, st_next;
	logic [3:0]    cnt_reg, cnt_next;
	logic [7:0]    sh_reg, sh_next;
	logic [7:0]    tx_reg, tx_next;
	logic [7:0]    ptr_reg, ptr_next;
	logic          drv_reg, drv_next;
	logic          rd_reg, rd_next;
	logic          first_reg, first_next;
	logic          gc_reg, gc_next;
	logic          pend_reg, pend_next;
	logic [7:0]    ofs_reg, ofs_next;
	logic [BW-1:0] bcnt_reg, bcnt_next;
	logic          wr_reg, wr_next;
	logic [7:0]    wa_reg, wa_next;
	logic [7:0]    wd_reg, wd_next;

	csi_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i  ({scl_i, sda_i}),
		.sync_o   (sync_w)
	);

	assign scl_s = sync_w[1];
	assign sda_s = sync_w[0];

	csi_auto_track u_track (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.track_en_i (ofs_reg[csi_pkg::AUTO_BIT] & adaptive_mode_i),
		.avg_valid_i(avg_valid_i),
		.avg_i      (avg_i),
		.step_i     (range_step_i),
		.code_i     (ofs_reg[csi_pkg::CODE_W-1:0]),
		.upd_o      (trk_upd),
		.code_o     (trk_code)
	);

	// Read data of the pointed register; the pointer has no read path
	function automatic logic [7:0] rd_mux(input logic [7:0] p, input logic [7:0] ofs,
			input logic [7:0] ext);
		case (p)
			csi_pkg::PTR_OFFSET:   rd_mux = ofs;
			csi_pkg::PTR_SERIAL0:  rd_mux = SERIAL_NUM[31:24];
			csi_pkg::PTR_SERIAL1:  rd_mux = SERIAL_NUM[23:16];
			csi_pkg::PTR_SERIAL2:  rd_mux = SERIAL_NUM[15:8];
			csi_pkg::PTR_SERIAL3:  rd_mux = SERIAL_NUM[7:0];
			csi_pkg::PTR_IDENTITY: rd_mux = PART_ID;
			default:               rd_mux = ext;
		endcase
	endfunction

	assign scl_rise  = scl_s & ~scl_d_reg;
	assign scl_fall  = ~scl_s & scl_d_reg;
	assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign busy      = (bcnt_reg != '0);

	always_comb begin
		st_next    = st_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		tx_next    = tx_reg;
		ptr_next   = ptr_reg;
		drv_next   = drv_reg;
		rd_next    = rd_reg;
		first_next = first_reg;
		gc_next    = gc_reg;
		pend_next  = pend_reg;
		ofs_next   = ofs_reg;
		bcnt_next  = busy ? bcnt_reg - 1'b1 : bcnt_reg;
		wr_next    = 1'b0;
		wa_next    = wa_reg;
		wd_next    = wd_reg;
		if (trk_upd) begin
			ofs_next[csi_pkg::CODE_W-1:0] = trk_code;
		end
		if (scl_rise) begin
			sh_next = {sh_reg[6:0], sda_s};
			if (st_reg == ST_ADDR || st_reg == ST_RX) begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
		if (busy) begin
			// No acknowledge of any traffic while defaults reload
			st_next  = ST_IDLE;
			drv_next = 1'b0;
		end else if (stop_det) begin
			st_next  = ST_IDLE;
			drv_next = 1'b0;
			ptr_next = csi_pkg::PTR_STATUS;
		end else if (start_det) begin
			st_next  = ST_ADDR;
			cnt_next = '0;
			drv_next = 1'b0;
		end else if (scl_fall) begin
			case (st_reg)
				ST_ADDR: begin
					if (cnt_reg == csi_pkg::BITS_PER_BYTE) begin
						rd_next    = sh_reg[0];
						gc_next    = (sh_reg == {csi_pkg::GC_ADDR, 1'b0});
						first_next = 1'b1;
						if (sh_reg[7:1] == csi_pkg::DEV_ADDR ||
								sh_reg == {csi_pkg::GC_ADDR, 1'b0}) begin
							st_next  = ST_AACK;
							drv_next = 1'b1;
						end else begin
							st_next = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					cnt_next = '0;
					if (rd_reg) begin
						tx_next  = rd_mux(ptr_reg, ofs_reg, ext_rd_data_i);
						drv_next = ~tx_next[7];
						st_next  = ST_TX;
					end else begin
						drv_next = 1'b0;
						st_next  = ST_RX;
					end
				end
				ST_RX: begin
					if (cnt_reg == csi_pkg::BITS_PER_BYTE) begin
						st_next    = ST_RACK;
						drv_next   = 1'b1;
						first_next = 1'b0;
						if (gc_reg) begin
							if (sh_reg == csi_pkg::GC_RESET_CMD) begin
								pend_next = 1'b1;
							end else begin
								st_next  = ST_IDLE;
								drv_next = 1'b0;
							end
						end else if (first_reg) begin
							ptr_next  = sh_reg;
							pend_next = (sh_reg == csi_pkg::PTR_RESET_CMD);
						end else begin
							ptr_next = ptr_reg + 1'b1;
							if (ptr_reg == csi_pkg::PTR_OFFSET) begin
								ofs_next = sh_reg;
							end else if (ptr_reg < csi_pkg::PTR_SERIAL0) begin
								wr_next = 1'b1;
								wa_next = ptr_reg;
								wd_next = sh_reg;
							end
							// Read-only and unmapped targets are acknowledged only
						end
					end
				end
				ST_RACK: begin
					drv_next = 1'b0;
					cnt_next = '0;
					st_next  = ST_RX;
					if (pend_reg) begin
						pend_next = 1'b0;
						bcnt_next = RELOAD_LOAD;
						ofs_next  = csi_pkg::OFFSET_RESET;
						ptr_next  = csi_pkg::PTR_STATUS;
						st_next   = ST_IDLE;
					end
				end
				ST_TX: begin
					cnt_next = cnt_reg + 1'b1;
					if (cnt_reg == csi_pkg::BITS_PER_BYTE - 1'b1) begin
						drv_next = 1'b0;
						st_next  = ST_TACK;
					end else begin
						drv_next = ~tx_reg[3'(6 - cnt_reg)];
					end
				end
				ST_TLOAD: begin
					tx_next  = rd_mux(ptr_reg, ofs_reg, ext_rd_data_i);
					drv_next = ~tx_next[7];
					cnt_next = '0;
					st_next  = ST_TX;
				end
				default: begin
				end
			endcase
		end else if (scl_rise && st_reg == ST_TACK) begin
			if (sda_s) begin
				st_next = ST_IDLE;
			end else begin
				ptr_next = ptr_reg + 1'b1;
				st_next  = ST_TLOAD;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			st_reg    <= ST_IDLE;
			cnt_reg   <= '0;
			sh_reg    <= '0;
			tx_reg    <= '0;
			ptr_reg   <= csi_pkg::PTR_STATUS;
			drv_reg   <= 1'b0;
			rd_reg    <= 1'b0;
			first_reg <= 1'b0;
			gc_reg    <= 1'b0;
			pend_reg  <= 1'b0;
			ofs_reg   <= csi_pkg::OFFSET_RESET;
			bcnt_reg  <= '0;
			wr_reg    <= 1'b0;
			wa_reg    <= '0;
			wd_reg    <= '0;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			tx_reg    <= tx_next;
			ptr_reg   <= ptr_next;
			drv_reg   <= drv_next;
			rd_reg    <= rd_next;
			first_reg <= first_next;
			gc_reg    <= gc_next;
			pend_reg  <= pend_next;
			ofs_reg   <= ofs_next;
			bcnt_reg  <= bcnt_next;
			wr_reg    <= wr_next;
			wa_reg    <= wa_next;
			wd_reg    <= wd_next;
		end
	end

	// Open drain: only ever pull low
	assign sda_o      = 1'b0;
	assign sda_oe_n_o = ~drv_reg;

	assign ext_addr_o    = ptr_reg;
	assign ext_wr_o      = wr_reg;
	assign ext_wr_addr_o = wa_reg;
	assign ext_wr_data_o = wd_reg;
	assign reload_o      = busy;

	assign offset_dac_enable_o        = ofs_reg[csi_pkg::DAC_EN_BIT];
	assign offset_auto_track_enable_o = ofs_reg[csi_pkg::AUTO_BIT];
	assign offset_code_o              = ofs_reg[csi_pkg::CODE_W-1:0];
endmodule
`default_nettype wire

// ---- csi_slave_monitor.sv ----
// Assertion checker of the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module csi_slave_monitor #(
	parameter int RELOAD_CYC = csi_pkg::RELOAD_CYCLES
) (
	// Clock, reset and bus
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        scl_i,
	input wire logic        sda_i,
	input wire logic        sda_oe_n_o,
	// Register side
	input wire logic [7:0]  ext_addr_o,
	input wire logic        ext_wr_o,
	input wire logic [7:0]  ext_wr_addr_o,
	input wire logic        reload_o,
	// Converter side
	input wire logic        adaptive_mode_i,
	input wire logic        avg_valid_i,
	input wire logic [15:0] avg_i,
	input wire logic [5:0]  range_step_i,
	input wire logic        offset_dac_enable_o,
	input wire logic        offset_auto_track_enable_o,
	input wire logic [5:0]  offset_code_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	logic [7:0]  offs;
	logic [6:0]  up_sum;
	logic [5:0]  up_exp;
	logic [5:0]  dn_exp;
	logic [31:0] rl_cnt_reg;
	logic [31:0] rl_cnt_next;
	assign offs = {offset_dac_enable_o, offset_auto_track_enable_o, offset_code_o};
	always_comb begin
		up_sum = {1'b0, offset_code_o} + {1'b0, range_step_i};
		up_exp = up_sum[6] ? 6'h3F : up_sum[5:0];
		dn_exp = (offset_code_o < range_step_i) ? 6'h00 : offset_code_o - range_step_i;
		rl_cnt_next = reload_o ? rl_cnt_reg + 32'h1 : 32'h0;
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			rl_cnt_reg <= 32'h0;
		else
			rl_cnt_reg <= rl_cnt_next;
	end
	// A long high clock only occurs between frames, so no bus write races the check
	sequence s_bus_idle;
		(scl_i && !reload_o) [*8];
	endsequence
	sequence s_stop;
		scl_i ##1 (scl_i && $rose(sda_i));
	endsequence
	property p_track_up;
		s_bus_idle ##0 (adaptive_mode_i && offset_auto_track_enable_o && avg_valid_i
			&& avg_i > csi_pkg::AVG_HIGH) |-> ##2 offset_code_o == $past(up_exp, 2);
	endproperty
	a_track_up: assert property (p_track_up)
		else $error("offset code did not step up");
	property p_track_dn;
		s_bus_idle ##0 (adaptive_mode_i && offset_auto_track_enable_o && avg_valid_i
			&& avg_i < csi_pkg::AVG_LOW) |-> ##2 offset_code_o == $past(dn_exp, 2);
	endproperty
	a_track_dn: assert property (p_track_dn)
		else $error("offset code did not step down");
	property p_track_fixed;
		s_bus_idle ##0 (!adaptive_mode_i && avg_valid_i)
			|-> ##2 offset_code_o == $past(offset_code_o, 2);
	endproperty
	a_track_fixed: assert property (p_track_fixed)
		else $error("offset code moved in fixed mode");
	property p_sda_low_phase;
		$changed(sda_oe_n_o) |-> !scl_i;
	endproperty
	a_sda_low_phase: assert property (p_sda_low_phase)
		else $error("data driver changed with clock high");
	property p_stop_ptr;
		s_stop |-> ##[1:8] ext_addr_o == csi_pkg::PTR_STATUS;
	endproperty
	a_stop_ptr: assert property (p_stop_ptr)
		else $error("pointer not cleared by stop");
	property p_ext_pulse;
		ext_wr_o |=> !ext_wr_o;
	endproperty
	a_ext_pulse: assert property (p_ext_pulse)
		else $error("write strobe longer than one cycle");
	property p_ext_addr;
		ext_wr_o |-> ext_wr_addr_o < csi_pkg::PTR_SERIAL0 && ext_wr_addr_o != csi_pkg::PTR_OFFSET;
	endproperty
	a_ext_addr: assert property (p_ext_addr)
		else $error("write strobe at invalid address");
	property p_reload_quiet;
		reload_o ##1 reload_o |-> sda_oe_n_o;
	endproperty
	a_reload_quiet: assert property (p_reload_quiet)
		else $error("acknowledge during reload");
	property p_reload_len;
		$fell(reload_o) |-> rl_cnt_reg == 32'(RELOAD_CYC) && offs == csi_pkg::OFFSET_RESET;
	endproperty
	a_reload_len: assert property (p_reload_len)
		else $error("reload length or defaults wrong");
	property p_reset_vals;
		$fell(sys_rst_i) |-> sda_oe_n_o && !reload_o && offs == csi_pkg::OFFSET_RESET;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset values wrong");
endmodule
bind csi_i2c_slave csi_slave_monitor #(.RELOAD_CYC(RELOAD_CYC)) u_mon (.clk_i, .sys_rst_i,
	.scl_i, .sda_i, .sda_oe_n_o, .ext_addr_o, .ext_wr_o, .ext_wr_addr_o, .reload_o,
	.adaptive_mode_i, .avg_valid_i, .avg_i, .range_step_i, .offset_dac_enable_o,
	.offset_auto_track_enable_o, .offset_code_o);
`default_nettype wire

// ---- csi_bus_master.sv ----
// Two-wire bus master model making clock and data
`timescale 1ns/1ps
`default_nettype none
module csi_bus_master (
	// Clock and wire level
	input  wire logic clk_i,
	input  wire logic sda_i,
	// Driven lines
	output logic      scl_o,
	output logic      sda_pull_o
);
	// Clock stands high between frames, data released to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_pull_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Data moves only in the low phase so no false start or stop appears
	task automatic put_bit(input logic b, output logic r);
		scl_o <= 1'b0;
		tick(2);
		sda_pull_o <= ~b;
		tick(3);
		scl_o <= 1'b1;
		tick(3);
		r = sda_i;
	endtask
	task automatic cond(input logic a, input logic b);
		scl_o <= 1'b0;
		tick(2);
		sda_pull_o <= a;
		tick(3);
		scl_o <= 1'b1;
		tick(3);
		sda_pull_o <= b;
		tick(5);
	endtask
	task automatic start_c;
		cond(1'b0, 1'b1);
	endtask
	task automatic stop_c;
		cond(1'b1, 1'b0);
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) put_bit(b[i], r);
		put_bit(1'b1, r);
		ack = (r === 1'b0);
	endtask
	task automatic recv(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
		put_bit(last, r);
	endtask
endmodule
`default_nettype wire

// ---- csi_i2c_slave_tb.sv ----
// Self-checking testbench of the two-wire slave port
`timescale 1ns/1ps
`default_nettype none
module csi_i2c_slave_tb;
	localparam logic [31:0] SER = 32'hA1B2C3D4; // Arbitrary value
	localparam logic [7:0]  PID = 8'h5C;        // Arbitrary value
	localparam logic [35:0] TBL [9] = '{36'h0_D000_03_05, 36'h1_D000_03_08, 36'h1_C000_03_08,
		36'h1_3000_03_05, 36'h1_4000_03_05, 36'h1_8000_03_05, 36'h1_FFFF_3F_3F,
		36'h1_0000_3F_00, 36'h1_0000_01_00};
	logic        clk, rst, scl, pull, sda, sda_o, oe_n, ext_wr, reload, adapt, avg_v, en, au;
	logic [5:0]  code, step;
	logic [7:0]  ext_a, ext_wa, ext_wd, wr_cnt, wr_a, wr_d, offs;
	logic [15:0] avg;
	int          mismatches, compares, cyc;
	assign offs = {en, au, code};
	assign sda = ~pull & (oe_n | sda_o);
	csi_bus_master m (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
	csi_i2c_slave #(.RELOAD_CYC(400), .SERIAL_NUM(SER), .PART_ID(PID)) uut (.clk_i(clk),
		.sys_rst_i(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
		.ext_addr_o(ext_a), .ext_rd_data_i(ext_a ^ 8'h5A), .ext_wr_o(ext_wr),
		.ext_wr_addr_o(ext_wa), .ext_wr_data_o(ext_wd), .reload_o(reload),
		.adaptive_mode_i(adapt), .avg_valid_i(avg_v), .avg_i(avg), .range_step_i(step),
		.offset_dac_enable_o(en), .offset_auto_track_enable_o(au), .offset_code_o(code));
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (ext_wr) begin
			wr_cnt <= wr_cnt + 8'h01;
			wr_a <= ext_wa;
			wr_d <= ext_wd;
		end
		if (cyc == 20000) begin
			mismatches++;
			complete_run();
		end
	end
	task automatic complete_run;
		if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic sendc(input logic [7:0] b, input logic e);
		logic a;
		m.send(b, a);
		chk("ack", {7'h00, e}, {7'h00, a});
	endtask
	task automatic recvc(input logic last, input logic [7:0] e);
		logic [7:0] d;
		m.recv(last, d);
		chk("rdata", e, d);
	endtask
	task automatic wr_off(input logic [7:0] v);
		m.start_c();
		sendc(8'h90, 1'b1);
		sendc(csi_pkg::PTR_OFFSET, 1'b1);
		sendc(v, 1'b1);
		m.stop_c();
	endtask
	task automatic track(input logic [35:0] t);
		repeat (8) @(posedge clk);
		adapt <= t[32];
		avg <= t[31:16];
		step <= t[13:8];
		avg_v <= 1'b1;
		@(posedge clk);
		avg_v <= 1'b0;
		repeat (3) @(posedge clk);
		chk("code", {2'b00, t[5:0]}, {2'b00, code});
	endtask
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{adapt, avg_v, avg, step, wr_cnt, mismatches, compares, cyc} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		chk("offset", csi_pkg::OFFSET_RESET, offs);
		wr_off(8'h9A);
		chk("offset", 8'h9A, offs);
		m.start_c();
		sendc(8'h90, 1'b1);
		sendc(8'h10, 1'b1);
		for (int i = 0; i < 4; i++) sendc(8'h33 + 8'(i * 34), 1'b1);
		m.stop_c();
		chk("offset", 8'h55, offs);
		chk("wr_count", 8'h02, wr_cnt);
		chk("wr_addr", 8'h12, wr_a);
		chk("wr_data", 8'h77, wr_d);
		m.start_c();
		sendc(8'h90, 1'b1);
		sendc(csi_pkg::PTR_SERIAL0, 1'b1);
		m.start_c();
		sendc(8'h91, 1'b1);
		for (int i = 3; i >= 0; i--) recvc(1'b0, SER[i*8 +: 8]);
		recvc(1'b0, PID);
		recvc(1'b1, 8'h18 ^ 8'h5A);
		m.stop_c();
		for (int i = 0; i < 2; i++) begin
			m.start_c();
			sendc(8'h91, 1'b1);
			recvc(1'b0, 8'h5A);
			recvc(1'b1, 8'h5B);
			m.stop_c();
		end
		m.start_c();
		sendc(8'hA0, 1'b0);
		m.stop_c();
		m.start_c();
		sendc(8'h00, 1'b1);
		sendc(8'h05, 1'b0);
		m.stop_c();
		for (int i = 0; i < 2; i++) begin
			m.start_c();
			sendc(i == 0 ? 8'h90 : 8'h00, 1'b1);
			sendc(i == 0 ? csi_pkg::PTR_RESET_CMD : csi_pkg::GC_RESET_CMD, 1'b1);
			m.stop_c();
			chk("reload", 8'h01, {7'h00, reload});
			m.start_c();
			sendc(8'h90, 1'b0);
			m.stop_c();
			for (int k = 0; k < 1000 && reload === 1'b1; k++) @(posedge clk);
			chk("offset", csi_pkg::OFFSET_RESET, offs);
			wr_off(8'h9A);
		end
		wr_off(8'h45);
		foreach (TBL[i]) track(TBL[i]);
		wr_off(8'h05);
		track(36'h1_D000_03_05);
		complete_run();
	end
endmodule
`default_nettype wire
